//--- rtl/amp_ctl_pkg.sv
// Constants, register map and state encoding for the amplifier control block.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
// Function
// - Select input low enables the bridge amplifier; high enables the headphone amplifier.
// - At most one amplifier is active; the unselected one is held asleep.
// - Mute input low silences the selected amplifier; high lets it run.
// - A muted bridge amplifier turns on both bridges' low-side switches.
// - Power-down input low shuts the whole device down; high runs normally.
// - Fault status is a two-bit code on a low-order and high-order output.
// - With no fault both status bits read one.
// - Pump undervoltage drives low bit zero, high bit one, and grounds the load.
// - After pump recovery output resumes by itself but the pump code is held.
// - The held pump code clears only on a mute or power-down toggle or power cycle.
// - Over-temperature drives both status bits zero and grounds the load.
// - Output resumes by itself once the die has cooled by the hysteresis.
// - After cooling both bits stay zero until a mute or power-down toggle.
// - Thermal protection and reporting behave the same in headphone mode.
// - Low headphone supply disables the headphone amplifier, with no status report.
package amp_ctl_pkg;

   // APB address width and register byte offsets
   localparam int            ADDR_W       = 8;
   localparam logic [7:0]    OFS_STATE    = 8'h00;
   localparam logic [7:0]    OFS_IRQ_STAT = 8'h04;
   localparam logic [7:0]    OFS_IRQ_MASK = 8'h08;

   // Interrupt bits, shared by status and mask
   localparam int            NUM_IRQ      = 4;
   localparam int            IRQ_PUMP     = 0;
   localparam int            IRQ_HOT      = 1;
   localparam int            IRQ_PLOW     = 2;
   localparam int            IRQ_CLEAR    = 3;
   localparam logic [3:0]    IRQ_MASK_RST = 4'h0;
   localparam logic [3:0]    IRQ_STAT_RST = 4'h0;

   // Synchronised input vector layout
   localparam int            NUM_SYNC     = 8;
   localparam int            SYN_SEL      = 0;
   localparam int            SYN_MUTE     = 1;
   localparam int            SYN_PD       = 2;
   localparam int            SYN_PUMP     = 3;
   localparam int            SYN_HOT      = 4;
   localparam int            SYN_PLOW     = 5;
   localparam int            SYN_PIN_LO   = 6;
   localparam int            SYN_PIN_HI   = 7;
   // Idle pin levels, so no false mute or power-down edge follows reset
   localparam logic [7:0]    SYNC_RST     = 8'hc6;

   // State register field positions
   localparam int            RB_SYNC_LSB  = 0;
   localparam int            RB_PUMP_HELD = 8;
   localparam int            RB_HOT_HELD  = 9;
   localparam int            RB_STAT_LO   = 10;
   localparam int            RB_STAT_HI   = 11;
   localparam int            RB_OP_LSB    = 12;

   // Status codes as {high bit, low bit}
   localparam logic [1:0]    CODE_OK      = 2'h3;
   localparam logic [1:0]    CODE_PUMP    = 2'h2;
   localparam logic [1:0]    CODE_HOT     = 2'h0;

   // Analog thresholds applied by the sensors in front of this logic
   localparam int            THERM_HYST_C = 20;
   localparam int            PHONE_UV_MV  = 4500;

   // Operating state, one-hot
   typedef enum logic [3:0] {
      OP_OFF     = 4'h1,
      OP_RUN     = 4'h2,
      OP_MUTE    = 4'h4,
      OP_PROTECT = 4'h8
   } op_state_t;

endpackage : amp_ctl_pkg

//--- rtl/amp_in_sync.sv
// Two-stage synchroniser for the asynchronous pins and analog monitor flags.
// Assumes inputs may change at any time relative to clock.
`timescale 1ns/1ps
module amp_in_sync (
   // Clock and reset
   input  wire logic                           clock,
   input  wire logic                           rstn,
   // Raw and synchronised levels
   input  wire logic [amp_ctl_pkg::NUM_SYNC-1:0] async_in,
   output logic      [amp_ctl_pkg::NUM_SYNC-1:0] sync_out
);
   import amp_ctl_pkg::*;

   typedef struct packed {
      logic [NUM_SYNC-1:0] stage1;
      logic [NUM_SYNC-1:0] stage2;
   } sync_state_t;

   sync_state_t cs_q;
   sync_state_t cs_d;

   // Stage one feeds only stage two, so metastability never reaches logic
   always_comb begin
      cs_d        = cs_q;
      cs_d.stage1 = async_in;
      cs_d.stage2 = cs_q.stage1;
   end

   // Register both stages
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cs_q.stage1 <= SYNC_RST;
         cs_q.stage2 <= SYNC_RST;
      end else begin
         cs_q <= cs_d;
      end
   end

   assign sync_out = cs_q.stage2;

endmodule : amp_in_sync

//--- rtl/amp_mode_mute_fault_control.sv
// Mode, mute, shutdown and fault protection control with an APB register file.
// Assumes the thermal and supply monitors are analog comparators with their own
// hysteresis, and that pins and monitor flags are asynchronous to clock.
`timescale 1ns/1ps
module amp_mode_mute_fault_control (
   // Clock and reset
   input  wire logic                           clock,
   input  wire logic                           rstn,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [amp_ctl_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Host control pins
   input  wire logic                           amp_select,
   input  wire logic                           mute_n,
   input  wire logic                           powerdown_n,
   // Analog monitor flags
   input  wire logic                           pump_undervolt,
   input  wire logic                           over_temp,
   input  wire logic                           phone_supply_low,
   // Amplifier controls
   output logic                                bridge_enable,
   output logic                                phone_enable,
   output logic                                bridge_sleep,
   output logic                                phone_sleep,
   output logic                                low_side_on,
   output logic                                amp_mute,
   output logic                                chip_shutdown,
   // Open-drain status pair
   input  wire logic                           status_lo_i,
   output logic                                status_lo_o,
   output logic                                status_lo_oe,
   input  wire logic                           status_hi_i,
   output logic                                status_hi_o,
   output logic                                status_hi_oe,
   // Interrupt
   output logic                                irq
);
   import amp_ctl_pkg::*;

   typedef struct packed {
      op_state_t            state;
      logic                 mute_prev;
      logic                 pd_prev;
      logic                 pump_prev;
      logic                 hot_prev;
      logic                 plow_prev;
      logic                 pump_held;
      logic                 hot_held;
      logic                 bridge_en;
      logic                 phone_en;
      logic                 bridge_slp;
      logic                 phone_slp;
      logic                 low_side;
      logic                 muted;
      logic                 chip_off;
      logic                 stat_lo;
      logic                 stat_hi;
      logic [NUM_IRQ-1:0]   irq_stat;
      logic [NUM_IRQ-1:0]   irq_mask;
      logic                 irq;
      logic [31:0]          rdata;
   } ctl_state_t;

   ctl_state_t           cs_q;
   ctl_state_t           cs_d;
   logic [NUM_SYNC-1:0]  raw_in;
   logic [NUM_SYNC-1:0]  syn;
   logic                 sel_s;
   logic                 mute_s;
   logic                 pd_s;
   logic                 pump_s;
   logic                 hot_s;
   logic                 plow_s;
   logic                 clr;
   logic [NUM_IRQ-1:0]   ev;
   logic [NUM_IRQ-1:0]   w1c;
   logic [2:0]           hit;

   // One-hot register decode {mask, status, state}; zero means unmapped
   function automatic logic [2:0] reg_hit(input logic [ADDR_W-1:0] a);
      logic [2:0] h;
      h = 3'h0;
      if (a == OFS_STATE) begin
         h = 3'h1;
      end
      if (a == OFS_IRQ_STAT) begin
         h = 3'h2;
      end
      if (a == OFS_IRQ_MASK) begin
         h = 3'h4;
      end
      return h;
   endfunction : reg_hit

   // Every pin and monitor flag crosses two flops before use
   assign raw_in[SYN_SEL]    = amp_select;
   assign raw_in[SYN_MUTE]   = mute_n;
   assign raw_in[SYN_PD]     = powerdown_n;
   assign raw_in[SYN_PUMP]   = pump_undervolt;
   assign raw_in[SYN_HOT]    = over_temp;
   assign raw_in[SYN_PLOW]   = phone_supply_low;
   assign raw_in[SYN_PIN_LO] = status_lo_i;
   assign raw_in[SYN_PIN_HI] = status_hi_i;

   amp_in_sync u_sync (
      .clock    (clock),
      .rstn     (rstn),
      .async_in (raw_in),
      .sync_out (syn)
   );

   // Named views of the synchronised levels
   assign sel_s  = syn[SYN_SEL];
   assign mute_s = syn[SYN_MUTE];
   assign pd_s   = syn[SYN_PD];
   assign pump_s = syn[SYN_PUMP];
   assign hot_s  = syn[SYN_HOT];
   assign plow_s = syn[SYN_PLOW];

   // Clearing toggle: a return high after a low period on mute or power-down
   assign clr = (mute_s & ~cs_q.mute_prev) | (pd_s & ~cs_q.pd_prev);

   // Interrupt events are rising edges of the fault flags and clearing toggles while a flag is held
   assign ev[IRQ_PUMP]  = pump_s & ~cs_q.pump_prev;
   assign ev[IRQ_HOT]   = hot_s & ~cs_q.hot_prev;
   assign ev[IRQ_PLOW]  = plow_s & ~cs_q.plow_prev;
   assign ev[IRQ_CLEAR] = clr & (cs_q.pump_held | cs_q.hot_held);

   // Bus decode and write-one-to-clear mask
   assign hit = reg_hit(paddr);
   assign w1c = (psel & penable & pwrite & hit[1]) ? pwdata[NUM_IRQ-1:0] : IRQ_STAT_RST;

   // Next-state logic for the whole block
   always_comb begin
      cs_d           = cs_q;
      cs_d.mute_prev = mute_s;
      cs_d.pd_prev   = pd_s;
      cs_d.pump_prev = pump_s;
      cs_d.hot_prev  = hot_s;
      cs_d.plow_prev = plow_s;

      // Held flags: a live fault wins over a clear in the same cycle
      cs_d.pump_held = pump_s | (cs_q.pump_held & ~clr);
      cs_d.hot_held  = hot_s | (cs_q.hot_held & ~clr);

      // Operating state; shutdown first, then live faults, then mute
      case (cs_q.state)
         OP_OFF, OP_RUN, OP_MUTE, OP_PROTECT: begin
            if (!pd_s) begin
               cs_d.state = OP_OFF;
            end else if (pump_s | hot_s) begin
               cs_d.state = OP_PROTECT;
            end else if (!mute_s) begin
               cs_d.state = OP_MUTE;
            end else begin
               cs_d.state = OP_RUN;
            end
         end
         default: begin
            cs_d.state = OP_OFF;
         end
      endcase

      // Amplifier controls follow the next state, registered
      cs_d.bridge_en  = 1'b0;
      cs_d.phone_en   = 1'b0;
      cs_d.bridge_slp = sel_s;
      cs_d.phone_slp  = ~sel_s;
      cs_d.low_side   = 1'b0;
      cs_d.muted      = 1'b0;
      cs_d.chip_off   = 1'b0;
      case (cs_d.state)
         OP_RUN: begin
            cs_d.bridge_en = ~sel_s;
            cs_d.phone_en  = sel_s & ~plow_s;
         end
         OP_MUTE: begin
            cs_d.muted    = 1'b1;
            cs_d.low_side = ~sel_s;
         end
         OP_PROTECT: begin
            cs_d.low_side = 1'b1;
         end
         OP_OFF: begin
            cs_d.chip_off   = 1'b1;
            cs_d.bridge_slp = 1'b1;
            cs_d.phone_slp  = 1'b1;
         end
         default: begin
            cs_d.chip_off = 1'b1;
         end
      endcase

      // Status code from held flags; thermal has priority
      if (cs_d.hot_held) begin
         {cs_d.stat_hi, cs_d.stat_lo} = CODE_HOT;
      end else if (cs_d.pump_held) begin
         {cs_d.stat_hi, cs_d.stat_lo} = CODE_PUMP;
      end else begin
         {cs_d.stat_hi, cs_d.stat_lo} = CODE_OK;
      end

      // Interrupt status and mask; a new event wins over a same-cycle clear
      cs_d.irq_stat = ev | (cs_q.irq_stat & ~w1c);
      if (psel & penable & pwrite & hit[2]) begin
         cs_d.irq_mask = pwdata[NUM_IRQ-1:0];
      end
      cs_d.irq = |(cs_d.irq_stat & cs_d.irq_mask);

      // Read data captured in the setup phase so prdata comes from a flop
      if (psel & ~penable & ~pwrite) begin
         cs_d.rdata = 32'h0;
         if (hit[0]) begin
            cs_d.rdata[RB_SYNC_LSB +: NUM_SYNC] = syn;
            cs_d.rdata[RB_PUMP_HELD]            = cs_q.pump_held;
            cs_d.rdata[RB_HOT_HELD]             = cs_q.hot_held;
            cs_d.rdata[RB_STAT_LO]              = cs_q.stat_lo;
            cs_d.rdata[RB_STAT_HI]              = cs_q.stat_hi;
            cs_d.rdata[RB_OP_LSB +: 4]          = cs_q.state;
         end
         if (hit[1]) begin
            cs_d.rdata[NUM_IRQ-1:0] = cs_q.irq_stat;
         end
         if (hit[2]) begin
            cs_d.rdata[NUM_IRQ-1:0] = cs_q.irq_mask;
         end
      end
   end

   // State register; reset stands for a supply power cycle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cs_q            <= '0;
         cs_q.state      <= OP_OFF;
         cs_q.chip_off   <= 1'b1;
         cs_q.bridge_slp <= 1'b1;
         cs_q.phone_slp  <= 1'b1;
         cs_q.stat_lo    <= 1'b1;
         cs_q.stat_hi    <= 1'b1;
         cs_q.mute_prev  <= SYNC_RST[SYN_MUTE];
         cs_q.pd_prev    <= SYNC_RST[SYN_PD];
         cs_q.irq_mask   <= IRQ_MASK_RST;
         cs_q.irq_stat   <= IRQ_STAT_RST;
      end else begin
         cs_q <= cs_d;
      end
   end

   // Zero-wait slave; unmapped offsets answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~|hit;
   assign prdata  = cs_q.rdata;

   // Amplifier control outputs
   assign bridge_enable = cs_q.bridge_en;
   assign phone_enable  = cs_q.phone_en;
   assign bridge_sleep  = cs_q.bridge_slp;
   assign phone_sleep   = cs_q.phone_slp;
   assign low_side_on   = cs_q.low_side;
   assign amp_mute      = cs_q.muted;
   assign chip_shutdown = cs_q.chip_off;

   // Open drain: pull low for a zero bit, release for a one
   assign status_lo_o  = 1'b0;
   assign status_lo_oe = ~cs_q.stat_lo;
   assign status_hi_o  = 1'b0;
   assign status_hi_oe = ~cs_q.stat_hi;
   assign irq          = cs_q.irq;

   // Never both amplifiers enabled, and exactly one asleep while powered
   chk_one_active: assert property (
      @(posedge clock) disable iff (!rstn)
      !chip_shutdown |-> !(bridge_enable && phone_enable) && (bridge_sleep != phone_sleep))
      else $error("both amplifiers active or sleep state wrong");

   // Clean bridge-mode conditions enable the bridge next cycle
   chk_sel_bridge: assert property (
      @(posedge clock) disable iff (!rstn)
      (pd_s && mute_s && !pump_s && !hot_s && !sel_s) |=> bridge_enable && !low_side_on)
      else $error("bridge not enabled when selected");

   // Muted bridge grounds the load
   chk_mute_ground: assert property (
      @(posedge clock) disable iff (!rstn)
      (pd_s && !mute_s && !pump_s && !hot_s && !sel_s) |=> low_side_on && amp_mute && !bridge_enable)
      else $error("muted bridge did not ground load");

   // Power-down low shuts everything off
   chk_pd_off: assert property (
      @(posedge clock) disable iff (!rstn)
      !pd_s |=> chip_shutdown && !bridge_enable && !phone_enable && !low_side_on)
      else $error("power-down did not shut down");

   // Live fault grounds the load in either mode
   chk_fault_ground: assert property (
      @(posedge clock) disable iff (!rstn)
      (pd_s && (pump_s || hot_s)) |=> low_side_on && !bridge_enable && !phone_enable)
      else $error("fault did not ground load");

   // Pins show the code of the held flags, thermal first
   chk_code_map: assert property (
      @(posedge clock) disable iff (!rstn)
      cs_q.hot_held |-> status_lo_oe && status_hi_oe)
      else $error("thermal code not shown");

   chk_pump_code: assert property (
      @(posedge clock) disable iff (!rstn)
      (cs_q.pump_held && !cs_q.hot_held) |-> status_lo_oe && !status_hi_oe)
      else $error("pump code not shown");

   // Held fault survives recovery until a toggle
   chk_hold_fault: assert property (
      @(posedge clock) disable iff (!rstn)
      (cs_q.pump_held && !clr) |=> cs_q.pump_held)
      else $error("pump fault dropped without toggle");

   // A mute return high with no live fault clears both held flags
   chk_toggle_clr: assert property (
      @(posedge clock) disable iff (!rstn)
      ($rose(mute_s) && !pump_s && !hot_s) |=> !cs_q.pump_held && !cs_q.hot_held && !status_lo_oe)
      else $error("toggle did not clear status");

   // Low headphone supply disables the headphone without touching status
   chk_phone_low: assert property (
      @(posedge clock) disable iff (!rstn)
      (plow_s && !pump_s && !hot_s && !clr) |=> !phone_enable && $stable(status_lo_oe) && $stable(status_hi_oe))
      else $error("headphone supply drop handled wrong");

endmodule : amp_mode_mute_fault_control

//--- tb/host_pins.sv
// Host model: drives the three control pins and reads the open-drain status pair.
// Assumes a board pull-up on each status line, so a released line reads one.
`timescale 1ns/1ps
module host_pins (
   // Clock
   input  wire logic clock,
   // Requested pin levels from the bench
   input  wire logic want_sel,
   input  wire logic want_mute_n,
   input  wire logic want_pd_n,
   // Pin drive
   output logic      amp_select,
   output logic      mute_n,
   output logic      powerdown_n,
   // Open-drain status pair
   input  wire logic lo_o,
   input  wire logic lo_oe,
   input  wire logic hi_o,
   input  wire logic hi_oe,
   output logic      status_lo,
   output logic      status_hi
);
   // Quiet levels from time zero: headphone off, not muted, running
   initial begin
      amp_select  = 1'b0;
      mute_n      = 1'b1;
      powerdown_n = 1'b1;
   end

   // Pins move only just after an edge; a low period then a return high is a toggle
   always @(posedge clock) begin
      amp_select  <= want_sel;
      mute_n      <= want_mute_n;
      powerdown_n <= want_pd_n;
   end

   // Wired level: the pull-up wins unless the device pulls low
   assign status_lo = lo_oe ? lo_o : 1'b1;
   assign status_hi = hi_oe ? hi_o : 1'b1;
endmodule : host_pins

//--- tb/amp_mode_mute_fault_control_tb_top.sv
// Self-checking bench for the amplifier mode, mute and fault control block.
// Assumes the host pin model in host_pins and the zero-wait APB slave.
`timescale 1ns/1ps
module amp_mode_mute_fault_control_tb_top;
   import amp_ctl_pkg::*;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq;
   logic        amp_select, mute_n, powerdown_n, st_lo, st_hi;
   logic        pump = 1'b0;
   logic        hot = 1'b0;
   logic        plow = 1'b0;
   logic [2:0]  want = 3'h6;
   logic [6:0]  ctl;
   logic        lo_o, lo_oe, hi_o, hi_oe;
   logic [5:0]  cur = 6'h06;
   logic        ph = 1'b0;
   logic        hh = 1'b0;
   logic [15:0] seed = 16'h1be4;
   int          num_errors = 0;
   int          checked = 0;
   int          cycles = 0;

   always #5 clock = ~clock;

   amp_mode_mute_fault_control dut (
      .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .amp_select(amp_select), .mute_n(mute_n),
      .powerdown_n(powerdown_n), .pump_undervolt(pump), .over_temp(hot),
      .phone_supply_low(plow), .bridge_enable(ctl[6]), .phone_enable(ctl[5]),
      .bridge_sleep(ctl[4]), .phone_sleep(ctl[3]), .low_side_on(ctl[2]),
      .amp_mute(ctl[1]), .chip_shutdown(ctl[0]), .status_lo_i(st_lo),
      .status_lo_o(lo_o), .status_lo_oe(lo_oe), .status_hi_i(st_hi),
      .status_hi_o(hi_o), .status_hi_oe(hi_oe), .irq(irq));

   host_pins host (
      .clock(clock), .want_sel(want[0]), .want_mute_n(want[1]), .want_pd_n(want[2]),
      .amp_select(amp_select), .mute_n(mute_n), .powerdown_n(powerdown_n),
      .lo_o(lo_o), .lo_oe(lo_oe), .hi_o(hi_o), .hi_oe(hi_oe),
      .status_lo(st_lo), .status_hi(st_hi));

   task automatic stop_test;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Hang guard: the whole run needs under two thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Returns {care, value}; value bits follow the ctl bus order
   function automatic logic [13:0] expect_ctl(input logic [5:0] v);
      if (!v[2]) return {7'h7f, 7'h19};
      if (v[3] | v[4]) return {7'h05, 7'h04};
      if (!v[1]) return {7'h07, 4'h0, !v[0], 2'h2};
      return {7'h7f ^ {3'h0, v[0] & v[5], 3'h0},
              !v[0], v[0] & !v[5], v[0], !v[0], 3'h0};
   endfunction : expect_ctl

   // One APB transfer; waits for pready however long, only the hang guard ends a wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge clock);
      #1;
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask : irq_is

   // Apply a new set of pin and monitor levels, then check the settled outputs
   task automatic apply(input logic [5:0] v);
      logic [31:0] rd;
      logic        er;
      logic        rise;
      logic [13:0] ex;
      logic [1:0]  code;
      rise = (!cur[1] & v[1]) | (!cur[2] & v[2]);
      if (v[3]) ph = 1'b1;
      else if (rise) ph = 1'b0;
      if (v[4]) hh = 1'b1;
      else if (rise) hh = 1'b0;
      code = hh ? CODE_HOT : (ph ? CODE_PUMP : CODE_OK);
      @(posedge clock);
      {plow, hot, pump} <= v[5:3];
      want <= v[2:0];
      cur = v;
      repeat (6) @(posedge clock);
      #1;
      ex = expect_ctl(v);
      check("ctl", {25'h0, ctl & ex[13:7]}, {25'h0, ex[6:0] & ex[13:7]});
      if (v[2]) check("status", {30'h0, st_hi, st_lo}, {30'h0, code});
      apb(1'b0, OFS_STATE, 32'h0, rd, er);
      check("held", {30'h0, rd[9:8]}, {30'h0, hh, ph});
   endtask : apply

   initial begin
      logic [31:0] rd;
      logic        er;
      logic [5:0]  nv;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      // Mask reset value, a refused unmapped access, an accepted write to the read-only state register, and the interrupt path
      apb(1'b0, OFS_IRQ_MASK, 32'h0, rd, er);
      check("mask_rst", rd, {28'h0, IRQ_MASK_RST});
      apb(1'b0, 8'h0c, 32'h0, rd, er);
      check("unmapped_err", {31'h0, er}, 32'h1);
      check("unmapped_data", rd, 32'h0);
      apb(1'b1, OFS_STATE, 32'hffff, rd, er);
      check("ro_err", {31'h0, er}, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h2, rd, er);
      apply(6'h16);
      irq_is(1'b1);
      apb(1'b1, OFS_IRQ_MASK, 32'h0, rd, er);
      irq_is(1'b0);
      apb(1'b1, OFS_IRQ_MASK, 32'h2, rd, er);
      irq_is(1'b1);
      apb(1'b1, OFS_IRQ_STAT, 32'h2, rd, er);
      irq_is(1'b0);
      $display("test irq done");
      // Cooling keeps the code; a mute toggle clears it
      apply(6'h06);
      apply(6'h04);
      apply(6'h06);
      apb(1'b0, OFS_IRQ_STAT, 32'h0, rd, er);
      check("cleared_evt", {31'h0, rd[3]}, 32'h1);
      // Headphone mode: thermal, then pump held under it, cleared by power-down
      apply(6'h17);
      apply(6'h07);
      apply(6'h0f);
      apply(6'h07);
      apply(6'h03);
      apply(6'h07);
      $display("test directed done");
      for (int i = 0; i < 150; i++) begin
         seed = lfsr(seed);
         nv = cur ^ (6'h01 << (seed[7:0] % 8'h06));
         if (nv[2] | !(nv[3] | nv[4])) apply(nv);
      end
      $display("test random done");
      // Pump held, then a power cycle clears it
      apply({3'h0, cur[2:0]} | 6'h0e);
      apply({3'h0, cur[2:0]} | 6'h06);
      @(posedge clock);
      rstn <= 1'b0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      ph = 1'b0;
      hh = 1'b0;
      apply(cur);
      $display("test power cycle done");
      stop_test();
   end
endmodule : amp_mode_mute_fault_control_tb_top
